// ===== rtl/tap_consts.vh
// Purpose: constants for the test access port controller
// Assumes: 3-bit instruction codes, 32-bit identification register
// Notes:   definitions only
`ifndef TAP_CONSTS_VH
`define TAP_CONSTS_VH
`define IR_LEN          3
`define OP_EXTEST       3'h0
`define OP_IDCODE       3'h1
`define OP_SAMPLE       3'h2
`define OP_CLAMP        3'h3
`define OP_HIGHZ        3'h4
`define OP_BYPASS       3'h7
`define IR_CAPTURE_VAL  3'h1
`define ID_LEN          32
`define ID_VALUE        32'h0000_0001
`define BSR_LEN_DEF     8
`endif

// ===== rtl/tap_controller.v
// Purpose: test access port with 16-state controller, 3-bit instruction register,
//          bypass, identification and boundary-scan registers
// Assumes: test clock is sampled by ref_clk and is much slower than it
// Notes:   tap edges are found from the synchronised test clock
// Operation
// - mode select sampled at test clock rise
// - reset gives Test-Logic-Reset with IDCODE
// - Run-Test-Idle holds all registers
// - Select-DR holds; low capture, high select-IR
// - Capture-DR loads selected register; then shift/exit1
// - Shift-DR shifts selected register toward output
// - Exit1-DR high update, low pause
// - Pause-DR holds; high goes Exit2-DR
// - Exit2-DR high update, low shift
// - Update-DR falling edge latches parallel outputs
// - Select-IR holds; low capture, high reset
// - Capture-IR loads fixed value; high exit1
// - Shift-IR shifts instruction; high goes Exit1-IR
// - Exit1-IR low pause, high update
// - Pause-IR holds while low; high exit2
// - Exit2-IR high goes Update-IR
// - instruction latched on falling edge in Update-IR
// - decode SAMPLE 010, EXTEST 000, BYPASS 111
// - decode CLAMP 011, HIGHZ 100, IDCODE 001
// - sample captures I/O, shift from input
// - bypass is one single-bit register
// - stopped test clock keeps state
`include "tap_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module tap_controller #(
  parameter BSR_LEN = `BSR_LEN_DEF
) (
  input  wire               ref_clk,         // system clock 50 MHz
  input  wire               reset,           // async reset, active high
  input  wire               tap_test_clock,  // test clock pin
  input  wire               tap_mode_select, // mode select pin
  input  wire               tap_serial_in,   // serial data in pin
  input  wire               tap_reset_n,     // test reset pin, active low
  input  wire [BSR_LEN-1:0] pin_sample,      // digital i/o levels to capture
  output reg                tap_serial_out,  // serial data out
  output reg                tap_serial_oe_n, // serial out enable, low drives
  output reg  [BSR_LEN-1:0] bsr_out,         // boundary parallel output latch
  output reg                bsr_drive,       // extest/clamp: pins take bsr_out
  output reg                pins_highz,      // highz: outputs released
  output reg  [`IR_LEN-1:0] instr_out        // current instruction
);
  localparam [15:0] S_TLR = 16'h0001;
  localparam [15:0] S_RTI = 16'h0002;
  localparam [15:0] S_SDR = 16'h0004;
  localparam [15:0] S_CDR = 16'h0008;
  localparam [15:0] S_SHD = 16'h0010;
  localparam [15:0] S_E1D = 16'h0020;
  localparam [15:0] S_PSD = 16'h0040;
  localparam [15:0] S_E2D = 16'h0080;
  localparam [15:0] S_UDR = 16'h0100;
  localparam [15:0] S_SIR = 16'h0200;
  localparam [15:0] S_CIR = 16'h0400;
  localparam [15:0] S_SHI = 16'h0800;
  localparam [15:0] S_E1I = 16'h1000;
  localparam [15:0] S_PSI = 16'h2000;
  localparam [15:0] S_E2I = 16'h4000;
  localparam [15:0] S_UIR = 16'h8000;

  reg  [2:0]         tck_r;
  reg  [1:0]         tms_r;
  reg  [1:0]         tdi_r;
  reg  [1:0]         trst_r;
  reg  [BSR_LEN-1:0] pin_meta_r;
  reg  [BSR_LEN-1:0] pin_sync_r;
  reg  [15:0]        state_r;
  reg  [15:0]        state_nxt;
  reg  [`IR_LEN-1:0] ir_sh_r;
  reg                byp_r;
  reg  [`ID_LEN-1:0] id_r;
  reg  [BSR_LEN-1:0] bsr_r;
  reg                tdo_nxt;
  reg                oe_nxt;
  wire               rise;
  wire               fall;
  wire               tms;
  wire               tdi;
  wire               sel_bsr;
  wire               sel_id;
  wire               in_tlr;
  wire               in_cdr;
  wire               in_shd;
  wire               in_udr;
  wire               in_cir;
  wire               in_shi;
  wire               in_uir;
  wire               ir_drive;
  wire               ir_highz;

  // two-stage synchronisers; tck_r[2] only feeds edge detection
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      tck_r  <= 3'h0;
      tms_r  <= 2'h3;
      tdi_r  <= 2'h3;
      trst_r <= 2'h0;
    end
    else
    begin
      tck_r  <= {tck_r[1:0], tap_test_clock};
      tms_r  <= {tms_r[0], tap_mode_select};
      tdi_r  <= {tdi_r[0], tap_serial_in};
      trst_r <= {trst_r[0], tap_reset_n};
    end
  end

  // device pins are not on ref_clk
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      pin_meta_r <= {BSR_LEN{1'b0}};
      pin_sync_r <= {BSR_LEN{1'b0}};
    end
    else
    begin
      pin_meta_r <= pin_sample;
      pin_sync_r <= pin_meta_r;
    end
  end

  assign rise     = tck_r[1] & ~tck_r[2];
  assign fall     = ~tck_r[1] & tck_r[2];
  assign tms      = tms_r[1];
  assign tdi      = tdi_r[1];
  assign sel_bsr  = (instr_out == `OP_SAMPLE) || (instr_out == `OP_EXTEST);
  assign sel_id   = (instr_out == `OP_IDCODE);
  assign in_tlr   = (state_r == S_TLR);
  assign in_cdr   = (state_r == S_CDR);
  assign in_shd   = (state_r == S_SHD);
  assign in_udr   = (state_r == S_UDR);
  assign in_cir   = (state_r == S_CIR);
  assign in_shi   = (state_r == S_SHI);
  assign in_uir   = (state_r == S_UIR);
  assign ir_drive = (ir_sh_r == `OP_EXTEST) || (ir_sh_r == `OP_CLAMP);
  assign ir_highz = (ir_sh_r == `OP_HIGHZ);

  always @*
  begin
    case (state_r)
      S_TLR:
        state_nxt = tms ? S_TLR : S_RTI;
      S_RTI:
        state_nxt = tms ? S_SDR : S_RTI;
      S_SDR:
        state_nxt = tms ? S_SIR : S_CDR;
      S_CDR:
        state_nxt = tms ? S_E1D : S_SHD;
      S_SHD:
        state_nxt = tms ? S_E1D : S_SHD;
      S_E1D:
        state_nxt = tms ? S_UDR : S_PSD;
      S_PSD:
        state_nxt = tms ? S_E2D : S_PSD;
      S_E2D:
        state_nxt = tms ? S_UDR : S_SHD;
      S_UDR:
        state_nxt = tms ? S_SDR : S_RTI;
      S_SIR:
        state_nxt = tms ? S_TLR : S_CIR;
      S_CIR:
        state_nxt = tms ? S_E1I : S_SHI;
      S_SHI:
        state_nxt = tms ? S_E1I : S_SHI;
      S_E1I:
        state_nxt = tms ? S_UIR : S_PSI;
      S_PSI:
        state_nxt = tms ? S_E2I : S_PSI;
      S_E2I:
        state_nxt = tms ? S_UIR : S_SHI;
      S_UIR:
        state_nxt = tms ? S_SDR : S_RTI;
      default:
        state_nxt = S_TLR;
    endcase
  end

  // state advances on test clock rise only
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      state_r <= S_TLR;
    else if (!trst_r[1])
      state_r <= S_TLR;
    else if (rise)
      state_r <= state_nxt;
  end

  // instruction shift stage
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      ir_sh_r <= `OP_IDCODE;
    else if (rise && in_cir)
      ir_sh_r <= `IR_CAPTURE_VAL;
    else if (rise && in_shi)
      ir_sh_r <= {tdi, ir_sh_r[`IR_LEN-1:1]};
  end

  // one-bit bypass stage, cleared at capture
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      byp_r <= 1'b0;
    else if (rise && in_cdr)
      byp_r <= 1'b0;
    else if (rise && in_shd && !sel_id && !sel_bsr)
      byp_r <= tdi;
  end

  // identification register, reloaded at capture
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      id_r <= `ID_VALUE;
    else if (rise && in_cdr && sel_id)
      id_r <= `ID_VALUE;
    else if (rise && in_shd && sel_id)
      id_r <= {tdi, id_r[`ID_LEN-1:1]};
  end

  // boundary shift path
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      bsr_r <= {BSR_LEN{1'b0}};
    else if (rise && in_cdr && sel_bsr)
      bsr_r <= pin_sync_r;
    else if (rise && in_shd && sel_bsr)
      bsr_r <= {tdi, bsr_r[BSR_LEN-1:1]};
  end

  // serial out source for the coming fall
  always @*
  begin
    tdo_nxt = byp_r;
    if (in_shi)
      tdo_nxt = ir_sh_r[0];
    else if (sel_id)
      tdo_nxt = id_r[0];
    else if (sel_bsr)
      tdo_nxt = bsr_r[0];
    oe_nxt = ~(in_shd | in_shi);
  end

  // instruction latch and pin controls, on test clock fall
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      instr_out  <= `OP_IDCODE;
      bsr_drive  <= 1'b0;
      pins_highz <= 1'b0;
    end
    else if (!trst_r[1] || in_tlr)
    begin
      instr_out  <= `OP_IDCODE;
      bsr_drive  <= 1'b0;
      pins_highz <= 1'b0;
    end
    else if (fall && in_uir)
    begin
      instr_out  <= ir_sh_r;
      bsr_drive  <= ir_drive;
      pins_highz <= ir_highz;
    end
  end

  // boundary latch copies the shift path at update
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      bsr_out <= {BSR_LEN{1'b0}};
    else if (fall && in_udr && sel_bsr && instr_out != `OP_CLAMP)
      bsr_out <= bsr_r;
  end

  // serial out and its enable, on test clock fall
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      tap_serial_out  <= 1'b0;
      tap_serial_oe_n <= 1'b1;
    end
    else if (!trst_r[1] || in_tlr)
      tap_serial_oe_n <= 1'b1;
    else if (fall)
    begin
      tap_serial_out  <= tdo_nxt;
      tap_serial_oe_n <= oe_nxt;
    end
  end
endmodule // tap_controller
`default_nettype wire

// ===== bench/tap_checker.sv
// Purpose: port checker for tap_controller
// Assumes: tap pins are slow against ref_clk
// Notes:   bound from the bench top
`include "tap_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module tap_checker #(
  parameter BSR_LEN = 8
) (
  input wire logic               ref_clk,        // system clock
  input wire logic               reset,          // async reset
  input wire logic               tap_test_clock, // test clock pin
  input wire logic               tap_reset_n,    // test reset pin
  input wire logic               tap_serial_out, // serial out
  input wire logic [BSR_LEN-1:0] bsr_out,        // boundary latch
  input wire logic               bsr_drive,      // pins take latch
  input wire logic               pins_highz,     // outputs released
  input wire logic [2:0]         instr_out       // current instruction
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_rst_id; $fell(reset) |-> instr_out == `OP_IDCODE; endproperty
  a_rst_id: assert property (p_rst_id) else $error("no idcode after reset");
  property p_trst; !tap_reset_n [*6] |-> instr_out == `OP_IDCODE; endproperty
  a_trst: assert property (p_trst) else $error("test reset ignored");
  property p_drive;
    $stable(instr_out) [*2] |-> bsr_drive == (instr_out inside {`OP_EXTEST, `OP_CLAMP});
  endproperty
  a_drive: assert property (p_drive) else $error("drive decode wrong");
  property p_highz; $stable(instr_out) [*2] |-> pins_highz == (instr_out == `OP_HIGHZ); endproperty
  a_highz: assert property (p_highz) else $error("highz decode wrong");
  property p_ir_fall;
    $changed(instr_out) && tap_reset_n && $past(tap_reset_n, 6) |-> !tap_test_clock;
  endproperty
  a_ir_fall: assert property (p_ir_fall) else $error("instr moved on high clock");
  property p_bsr_fall; $changed(bsr_out) |-> !tap_test_clock; endproperty
  a_bsr_fall: assert property (p_bsr_fall) else $error("latch moved on high clock");
  property p_out_fall; $changed(tap_serial_out) |-> !tap_test_clock; endproperty
  a_out_fall: assert property (p_out_fall) else $error("serial out moved early");
  property p_hold;
    (tap_reset_n && $stable(tap_test_clock)) [*8] |-> $stable(instr_out) && $stable(bsr_out);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved with clock stopped");
  c_byp: cover property (instr_out == `OP_BYPASS);
  c_drv: cover property (bsr_drive);
  c_hiz: cover property (pins_highz);
endmodule // tap_checker
`default_nettype wire

// ===== bench/tap_tester.sv
// Purpose: boundary-scan tester model on the tap pins
// Assumes: 8 ref_clk cycles per test clock period
// Notes:   test clock parks low between frames
`timescale 1ns/100ps
`default_nettype none
module tap_tester (
  input  wire logic ref_clk, // system clock
  input  wire logic tdo,     // serial out of the port
  output var  logic tck,     // test clock
  output var  logic tms,     // mode select
  output var  logic tdi      // serial in
);
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  task automatic cyc(input logic m, input logic d, output logic q);
    @(negedge ref_clk);
    tms = m;
    tdi = d;
    @(negedge ref_clk);
    q = tdo;
    tck = 1'b1;
    repeat (4) @(negedge ref_clk);
    tck = 1'b0;
    tdi = ~d;
    repeat (2) @(negedge ref_clk); // parked low until next call
  endtask
endmodule // tap_tester
`default_nettype wire

// ===== bench/tb_tap_controller.sv
// Purpose: self-checking bench for tap_controller
// Assumes: tester model owns the test clock, mode select and serial in pins; the bench drives the test reset pin
// Notes:   expectations follow the instruction table
`include "tap_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module tb_tap_controller;
  logic ref_clk, reset, trst_n;
  logic [7:0] pins;
  logic [31:0] q;
  int fail_count, checks_done;
  wire logic tck, tms, tdi, tdo, oe_n, drive, highz;
  wire logic [7:0] bsr;
  wire logic [2:0] instr;
  tap_tester i_tester (.ref_clk, .tdo, .tck, .tms, .tdi);
  tap_controller #(.BSR_LEN(8)) i_dut (.ref_clk, .reset, .tap_test_clock(tck),
    .tap_mode_select(tms), .tap_serial_in(tdi), .tap_reset_n(trst_n), .pin_sample(pins),
    .tap_serial_out(tdo), .tap_serial_oe_n(oe_n), .bsr_out(bsr), .bsr_drive(drive),
    .pins_highz(highz), .instr_out(instr));
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic sc(input bit ir, input int n, input logic [31:0] din, input int p);
    logic b;
    q = '0;
    i_tester.cyc(0, 0, b);
    i_tester.cyc(1, 0, b);
    if (ir) i_tester.cyc(1, 0, b);
    i_tester.cyc(0, 0, b);
    i_tester.cyc(0, 0, b);
    for (int i = 0; i < n; i++)
    begin
      i_tester.cyc(i == n - 1 || i == p, din[i], b);
      q[i] = b;
      if (i == p)
      begin
        i_tester.cyc(0, 0, b);
        i_tester.cyc(0, 0, b);
        i_tester.cyc(1, 0, b);
        i_tester.cyc(0, 0, b);
      end
    end
    i_tester.cyc(1, 0, b);
    i_tester.cyc(0, 0, b);
  endtask
  task automatic t_id;
    chk(instr, `OP_IDCODE);
    sc(0, 32, 0, 5);
    chk(q, `ID_VALUE);
    chk(oe_n, 1'b1);
    $display("t_id done");
  endtask
  task automatic t_ir;
    logic [2:0] ops [6] = '{`OP_EXTEST, `OP_IDCODE, `OP_SAMPLE, `OP_CLAMP, `OP_HIGHZ, `OP_BYPASS};
    for (int k = 0; k < 6; k++)
    begin
      sc(1, 3, ops[k], k == 3 ? 0 : -1);
      chk(q[2:0], `IR_CAPTURE_VAL);
      chk(instr, ops[k]);
      chk(drive, ops[k] == `OP_EXTEST || ops[k] == `OP_CLAMP);
      chk(highz, ops[k] == `OP_HIGHZ);
    end
    $display("t_ir done");
  endtask
  task automatic t_byp;
    sc(1, 3, `OP_BYPASS, -1);
    sc(0, 8, 32'hA5, 3);
    chk(q[7:0], 8'h4A);
    $display("t_byp done");
  endtask
  task automatic t_smp;
    pins = 8'h3C;
    sc(1, 3, `OP_SAMPLE, -1);
    sc(0, 8, 32'h96, -1);
    chk(q[7:0], 8'h3C);
    repeat (3) i_tester.cyc(0, 1, q[0]);
    chk(bsr, 8'h96);
    $display("t_smp done");
  endtask
  task automatic t_trst;
    trst_n = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk(instr, `OP_IDCODE);
    trst_n = 1'b1;
    $display("t_trst done");
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    fail_count = 0;
    checks_done = 0;
    reset = 1'b1;
    trst_n = 1'b1;
    pins = 8'h00;
    repeat (4) @(negedge ref_clk);
    reset = 1'b0;
    repeat (3) @(negedge ref_clk);
    t_id;
    t_ir;
    t_byp;
    t_smp;
    t_trst;
    t_id;
    end_of_test;
  end
  initial
  begin
    #1000000;
    fail_count++;
    end_of_test;
  end
endmodule // tb_tap_controller
bind tap_controller tap_checker #(.BSR_LEN(BSR_LEN)) i_chk (.ref_clk, .reset, .tap_test_clock,
  .tap_reset_n, .tap_serial_out, .bsr_out, .bsr_drive, .pins_highz, .instr_out);
`default_nettype wire
